// [test/nv_host_assertions.sv]
`timescale 1ns/1ps
module nv_host_chk
    import nv_host_pkg::*;
(
    // Clock, reset and user side
    input wire logic              clk, rst, req_valid, req_ready, rsp_valid, store_inhibited,
    input wire req_type           req,
    // Memory pins
    input wire logic              chip_en_n, out_en_n, write_en_n, nonvol_strobe_n,
    input wire logic              data_pins_oe_n,
    input wire logic [ADDR_W-1:0] addr_pins,
    input wire logic [DATA_W-1:0] data_pins_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_addr_held: assert property (!chip_en_n && !write_en_n |-> $stable(addr_pins))
        else $error("addr moved in write");
    a_data_valid: assert property (!write_en_n && nonvol_strobe_n
        |-> !data_pins_oe_n && $stable(data_pins_out)) else $error("write data moved");
    a_oe_high: assert property (!write_en_n |-> out_en_n) else $error("oe low in write");
    a_we_last: assert property ($fell(write_en_n) && !nonvol_strobe_n
        |-> !$past(chip_en_n) && !$past(nonvol_strobe_n) && $past(out_en_n))
        else $error("store entry order");
    a_store_release: assert property ($fell(write_en_n) && !nonvol_strobe_n
        |=> write_en_n ##1 (chip_en_n && nonvol_strobe_n)) else $error("store not released");
    a_recall_hold: assert property ($fell(out_en_n) && !nonvol_strobe_n
        |-> write_en_n throughout ##[1:3] nonvol_strobe_n) else $error("recall hold");
    a_store_refused: assert property (req_valid && req.cmd == CMD_STORE
        && store_inhibited && chip_en_n |=> chip_en_n) else $error("store taken when inhibited");
    a_read_answer: assert property (req_valid && req_ready && req.cmd == CMD_READ
        |-> ##6 rsp_valid) else $error("read answer late");
endmodule : nv_host_chk

// [test/nv_mem_model.sv]
`timescale 1ns/1ps
module nv_mem_model
    import nv_host_pkg::*;
#(
    parameter int STORE_NS  = 200,
    parameter int RECALL_NS = 1000
) (
    // Control pins and supply indicator
    input  wire logic chip_en_n, out_en_n, write_en_n, nonvol_strobe_n, store_ok,
    // Address and data
    input  wire logic [ADDR_W-1:0] addr_pins,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_drive
);
    logic [DATA_W-1:0] sram [NUM_BYTES], nv [NUM_BYTES];
    logic              busy = 1'b0;
    wire wr_s = !chip_en_n && !write_en_n && nonvol_strobe_n;
    wire st_s = !chip_en_n && !write_en_n && out_en_n && !nonvol_strobe_n;
    wire rc_s = !chip_en_n && !out_en_n && write_en_n && !nonvol_strobe_n;
    // Floats while busy or in a write; a read state after a transfer drives again
    assign dq_drive = !busy && !chip_en_n && !out_en_n
        && write_en_n && nonvol_strobe_n;
    assign dq_out = sram[addr_pins];
    always @(negedge wr_s) if (!busy) sram[addr_pins] = dq_in;
    // Edge triggered, so pins left in the store state cannot start a second one
    always @(posedge st_s) if (!busy && store_ok) begin
        busy = 1'b1;
        foreach (nv[i]) nv[i] = 8'hff;
        #(STORE_NS);
        foreach (nv[i]) nv[i] = sram[i];
        busy = 1'b0;
    end
    always @(posedge rc_s) if (!busy) begin
        busy = 1'b1;
        foreach (sram[i]) sram[i] = 8'h00;
        #(RECALL_NS);
        foreach (sram[i]) sram[i] = nv[i];
        busy = 1'b0;
    end
endmodule : nv_mem_model

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import nv_host_pkg::*;
;
    logic              clk = 1'b0, rst = 1'b1, req_valid = 1'b0, supply_low = 1'b0;
    logic              supply_store_ok = 1'b1, supply_sense_ok = 1'b1, mem_drive;
    logic              req_ready, rsp_valid, store_inhibited, data_pins_oe_n;
    logic              chip_en_n, out_en_n, write_en_n, nonvol_strobe_n;
    req_type           req = '0;
    logic [ADDR_W-1:0] addr_pins;
    logic [DATA_W-1:0] rsp_data, data_pins_out, data_pins_in, mem_q, q, bus_q = 8'h00;
    int                err_count = 0, n_checks = 0;
    // Undriven bus shows the inverse of its last level, so stale data cannot pass
    assign data_pins_in = !data_pins_oe_n ? data_pins_out : mem_drive ? mem_q : ~bus_q;
    always @(posedge clk) bus_q <= data_pins_in;
    nv_sram_store_recall #(.STORE_CYC(20), .POWER_UP_CYC(10)) dut (.*);
    // Model busy for the full worst case, so a short wait in the host reads stale data
    nv_mem_model #(.STORE_NS(20 * CLK_PERIOD_NS), .RECALL_NS(RECALL_MAX_US * 1000)) mem (
        .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
        .nonvol_strobe_n(nonvol_strobe_n), .store_ok(supply_store_ok), .addr_pins(addr_pins),
        .dq_in(data_pins_in), .dq_out(mem_q), .dq_drive(mem_drive));
    initial forever #10 clk = ~clk;
    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task close_out;
        if (err_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    task xfer(input cmd_type c, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(negedge clk);
        req = '{cmd: c, addr: a, wdata: d};
        req_valid = 1'b1;
        for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        for (n = 0; n < 1500 && rsp_valid !== 1'b1; n++) @(negedge clk);
        q = rsp_data;
        chk("rsp_valid", 8'h01, {7'h0, rsp_valid});
    endtask : xfer
    task t_power_up;
        int n;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clk);
        chk("power_up_wait", 8'h01, 8'(n >= 10 && n < 100));
    endtask : t_power_up
    task t_read_write;
        logic [ADDR_W-1:0] a [3] = '{13'h0000, 13'h1fff, 13'h0aaa};
        logic [DATA_W-1:0] d [3] = '{8'h3c, 8'hc3, 8'h55};
        foreach (a[i]) xfer(CMD_WRITE, a[i], d[i]);
        foreach (a[i]) begin
            xfer(CMD_READ, a[i], 8'h00);
            chk("read_data", d[i], q);
        end
    endtask : t_read_write
    task t_store_recall;
        xfer(CMD_WRITE, 13'h0123, 8'h5a);
        xfer(CMD_STORE, 13'h0000, 8'h00);
        xfer(CMD_WRITE, 13'h0123, 8'ha5);
        xfer(CMD_READ, 13'h0123, 8'h00);
        chk("sram_data", 8'ha5, q);
        repeat (2) begin
            xfer(CMD_RECALL, 13'h0000, 8'h00);
            xfer(CMD_READ, 13'h0123, 8'h00);
            chk("recalled", 8'h5a, q);
        end
    endtask : t_store_recall
    task t_inhibit;
        @(negedge clk);
        supply_store_ok = 1'b0;
        repeat (4) @(negedge clk);
        req = '{cmd: CMD_STORE, addr: 13'h0000, wdata: 8'h00};
        req_valid = 1'b1;
        repeat (3) @(negedge clk);
        chk("inhibited", 8'h01, {7'h0, store_inhibited});
        chk("store_ready", 8'h00, {7'h0, req_ready});
        req_valid = 1'b0;
        supply_store_ok = 1'b1;
        repeat (4) @(negedge clk);
        xfer(CMD_WRITE, 13'h0123, 8'h77);
        xfer(CMD_RECALL, 13'h0000, 8'h00);
        xfer(CMD_READ, 13'h0123, 8'h00);
        chk("not_stored", 8'h5a, q);
    endtask : t_inhibit
    task t_brownout;
        int n;
        @(negedge clk);
        supply_low      = 1'b1;
        supply_sense_ok = 1'b0;
        repeat (4) @(negedge clk);
        chk("low_ready", 8'h00, {7'h0, req_ready});
        supply_low = 1'b0;
        repeat (4) @(negedge clk);
        chk("below_sense_ready", 8'h00, {7'h0, req_ready});
        supply_sense_ok = 1'b1;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clk);
        chk("resume_wait", 8'h01, 8'(n >= 10 && n < 100));
        xfer(CMD_READ, 13'h0123, 8'h00);
        chk("after_low", 8'h5a, q);
    endtask : t_brownout
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_power_up();
        t_read_write();
        t_store_recall();
        t_inhibit();
        t_brownout();
        close_out();
    end
    // Recalls dominate the run; several times the expected span
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end
endmodule : tb_top

bind nv_sram_store_recall nv_host_chk u_chk (.*);

// [verilog/nv_host_pkg.sv]
package nv_host_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int NUM_BYTES = 8192;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int ACCESS_NS = 60;
    localparam int INIT_HOLD_NS = 20;
    localparam int RECALL_MAX_US = 20;
    localparam int STORE_MAX_MS = 10;
    localparam int POWER_UP_COPY_TIME_US = 550;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_HOLD_CYC = (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COPY_BACK_CYC = (RECALL_MAX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STORE_CYC_DEF = (STORE_MAX_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYC_DEF =
        (POWER_UP_COPY_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    // ------------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_READ   = 2'h0,
        CMD_WRITE  = 2'h1,
        CMD_STORE  = 2'h2,
        CMD_RECALL = 2'h3
    } cmd_type;

    typedef struct packed {
        cmd_type             cmd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } req_type;

    // Pins driven to the memory, all strobes active low
    typedef struct packed {
        logic                chip_en_n;
        logic                out_en_n;
        logic                write_en_n;
        logic                nonvol_strobe_n;
        logic [ADDR_W-1:0]   addr_pins;
        logic [DATA_W-1:0]   data_out;
        logic                data_oe_n;
    } pins_type;

endpackage : nv_host_pkg

// [verilog/nv_sram_store_recall.sv]
`timescale 1ns/1ps
// Functional notes
// - Host holds address stable through write
// - Data captured at write end edge
// - Keep output enable high during writes
// - Hold recall state at least 20 ns
// - Host waits out power-up recall
// - Keep write inactive at power-up end
// - Store ends within 10 ms
module nv_sram_store_recall
    import nv_host_pkg::*;
#(
    parameter int STORE_CYC    = STORE_CYC_DEF,
    parameter int POWER_UP_CYC = POWER_UP_CYC_DEF
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Request from user logic
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire req_type           req,
    // Answer to user logic
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_data,
    // Supply indicators, asynchronous in; store_inhibited is a synchronous output
    input  wire logic              supply_low,
    input  wire logic              supply_store_ok,
    input  wire logic              supply_sense_ok,
    output logic                   store_inhibited,
    // Memory pins
    output logic                   chip_en_n,
    output logic                   out_en_n,
    output logic                   write_en_n,
    output logic                   nonvol_strobe_n,
    output logic [ADDR_W-1:0]      addr_pins,
    output logic [DATA_W-1:0]      data_pins_out,
    output logic                   data_pins_oe_n,
    input  wire logic [DATA_W-1:0] data_pins_in
);

    typedef enum logic [2:0] {
        ST_POWER   = 3'b000,
        ST_IDLE    = 3'b001,
        ST_SETUP   = 3'b011,
        ST_STROBE  = 3'b010,
        ST_RELEASE = 3'b110,
        ST_WAIT    = 3'b111
    } state_type;

    typedef struct packed {
        state_type           st;
        cmd_type             cmd;
        logic [CNT_W-1:0]    cnt;
        pins_type            pins;
        logic                rsp_valid;
        logic [DATA_W-1:0]   rsp_data;
    } regs_type;

    localparam pins_type PINS_IDLE = '{chip_en_n: 1'b1, out_en_n: 1'b1,
        write_en_n: 1'b1, nonvol_strobe_n: 1'b1, addr_pins: '0,
        data_out: '0, data_oe_n: 1'b1};

    regs_type          r;
    regs_type          next_r;
    logic [2:0]        sup_sync;
    logic [DATA_W-1:0] din_sync;
    logic              low_s;
    logic              store_ok_s;
    logic              sense_s;

    // ------------------------------------------------------------------
    // Synchronisers for pins from outside the clock domain
    // ------------------------------------------------------------------
    nv_sync #(.W(3)) u_sup_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({supply_low, supply_store_ok, supply_sense_ok}),
        .dout (sup_sync)
    );

    nv_sync #(.W(DATA_W)) u_din_sync (
        .clk  (clk),
        .rst  (rst),
        .din  (data_pins_in),
        .dout (din_sync)
    );

    assign low_s      = sup_sync[2];
    assign store_ok_s = sup_sync[1];
    assign sense_s    = sup_sync[0];

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_r            = r;
        next_r.rsp_valid  = 1'b0;
        case (r.st)
            ST_POWER: begin
                // Count only while the supply is above the sense level and supply_low is clear
                next_r.pins = PINS_IDLE;
                if (low_s || !sense_s) begin
                    next_r.cnt = '0;
                end else if (r.cnt >= CNT_W'(POWER_UP_CYC - 1)) begin
                    next_r.st  = ST_IDLE;
                    next_r.cnt = '0;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            ST_IDLE: begin
                next_r.pins = PINS_IDLE;
                if (low_s) begin
                    next_r.st  = ST_POWER;
                    next_r.cnt = '0;
                end else if (req_valid
                             && !(req.cmd == CMD_STORE && !store_ok_s)) begin
                    next_r.cmd            = req.cmd;
                    next_r.cnt            = '0;
                    next_r.st             = ST_SETUP;
                    // Address and mode settle before out_en_n or write_en_n falls
                    next_r.pins.addr_pins = req.addr;
                    next_r.pins.data_out  = req.wdata;
                    next_r.pins.chip_en_n = 1'b0;
                    if (req.cmd != CMD_READ && req.cmd != CMD_RECALL) begin
                        next_r.pins.out_en_n = 1'b1;
                    end
                    if (req.cmd == CMD_STORE || req.cmd == CMD_RECALL) begin
                        next_r.pins.nonvol_strobe_n = 1'b0;
                    end
                    if (req.cmd == CMD_WRITE) begin
                        next_r.pins.data_oe_n = 1'b0;
                    end
                end
            end
            ST_SETUP: begin
                // Last pin moves here so the device sees one transition
                next_r.st  = ST_STROBE;
                next_r.cnt = '0;
                case (r.cmd)
                    CMD_READ:   next_r.pins.out_en_n   = 1'b0;
                    CMD_WRITE:  next_r.pins.write_en_n = 1'b0;
                    CMD_STORE:  next_r.pins.write_en_n = 1'b0;
                    CMD_RECALL: next_r.pins.out_en_n   = 1'b0;
                    default:    next_r.pins.out_en_n   = 1'b1;
                endcase
            end
            ST_STROBE: begin
                if (r.cmd == CMD_READ) begin
                    if (r.cnt >= CNT_W'(ACCESS_CYC)) begin
                        next_r.rsp_valid = 1'b1;
                        next_r.rsp_data  = din_sync;
                        next_r.pins      = PINS_IDLE;
                        next_r.st        = ST_IDLE;
                    end else begin
                        next_r.cnt = r.cnt + 1'b1;
                    end
                end else if (r.cnt >= CNT_W'(INIT_HOLD_CYC - 1)) begin
                    // Write data still driven at the rising write enable
                    next_r.pins.write_en_n = 1'b1;
                    next_r.cnt             = '0;
                    next_r.st              = ST_RELEASE;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            ST_RELEASE: begin
                next_r.pins.chip_en_n       = 1'b1;
                next_r.pins.nonvol_strobe_n = 1'b1;
                next_r.pins.out_en_n        = 1'b1;
                next_r.pins.data_oe_n       = 1'b1;
                next_r.st                   = (r.cmd == CMD_WRITE) ? ST_IDLE : ST_WAIT;
                next_r.rsp_valid            = (r.cmd == CMD_WRITE);
            end
            ST_WAIT: begin
                // Device is busy and ignores pins; wait the worst case
                if ((r.cmd == CMD_STORE && r.cnt >= CNT_W'(STORE_CYC - 1))
                    || (r.cmd == CMD_RECALL && r.cnt >= CNT_W'(COPY_BACK_CYC - 1))) begin
                    next_r.st        = ST_IDLE;
                    next_r.rsp_valid = 1'b1;
                end else begin
                    next_r.cnt = r.cnt + 1'b1;
                end
            end
            default: begin
                next_r.st   = ST_POWER;
                next_r.pins = PINS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r.st         <= ST_POWER;
            r.cmd        <= CMD_READ;
            r.cnt        <= '0;
            r.pins       <= PINS_IDLE;
            r.rsp_valid  <= 1'b0;
            r.rsp_data   <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign req_ready       = (r.st == ST_IDLE) && !low_s
                             && !(req.cmd == CMD_STORE && !store_ok_s);
    assign store_inhibited = !store_ok_s;
    assign rsp_valid       = r.rsp_valid;
    assign rsp_data        = r.rsp_data;
    assign chip_en_n       = r.pins.chip_en_n;
    assign out_en_n        = r.pins.out_en_n;
    assign write_en_n      = r.pins.write_en_n;
    assign nonvol_strobe_n = r.pins.nonvol_strobe_n;
    assign addr_pins       = r.pins.addr_pins;
    assign data_pins_out   = r.pins.data_out;
    assign data_pins_oe_n  = r.pins.data_oe_n;

endmodule : nv_sram_store_recall

// [verilog/nv_sync.sv]
`timescale 1ns/1ps
module nv_sync
    import nv_host_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stage1;

    // ------------------------------------------------------------------
    // Two-flop synchroniser per bit
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (rst) begin
                    stage1[i] <= 1'b0;
                    dout[i]   <= 1'b0;
                end else begin
                    stage1[i] <= din[i];
                    dout[i]   <= stage1[i];
                end
            end
        end
    endgenerate

endmodule : nv_sync
